//--- logic/epv_host.v
// Local design decision: the APB register port.
`include "epv_defines.vh"

// Behaviour
// - Verify: VPP high, VCC at 6.0V
// - Target program sets mask bit 6 first
// - Unused mode pins held at defined level
// - Unused address/data held at logic level
// - Option pulse lasts at least 78 ms
// - Read: mode select high, CE, OE low
// - 1 ms pulses, max 25, then 3x overpulse
module epv_host #(
	parameter [23:0] MS_CYC = `EPV_MS_CYC
) (
	clk,
	nrst,
	psel,
	penable,
	pwrite,
	paddr,
	pwdata,
	prdata,
	pready,
	pslverr,
	vpp_vh,
	vcc_prog,
	memory_mode_select_vh,
	memory_mode_select,
	ce_vh,
	ce_n,
	oe_vh,
	oe_n,
	program_strobe_n,
	addr,
	data_o,
	data_oe,
	data_i
);
	input wire clk;
	input wire nrst;
	input wire psel;
	input wire penable;
	input wire pwrite;
	input wire [7:0] paddr;
	input wire [31:0] pwdata;
	output reg [31:0] prdata;
	output wire pready;
	output wire pslverr;
	output reg vpp_vh;
	output reg vcc_prog;
	output reg memory_mode_select_vh;
	output reg memory_mode_select;
	output reg ce_vh;
	output reg ce_n;
	output reg oe_vh;
	output reg oe_n;
	output reg program_strobe_n;
	output reg [12:0] addr;
	output reg [7:0] data_o;
	output reg data_oe;
	input wire [7:0] data_i;

	localparam S_IDLE = 3'h0;
	localparam S_SETUP = 3'h1;
	localparam S_PULSE = 3'h2;
	localparam S_HOLD = 3'h3;
	localparam S_VERIFY = 3'h4;
	localparam S_END = 3'h5;

	reg rst_s1_r;
	reg rst_n;
	reg [7:0] din_s1_r;
	reg [7:0] din_r;
	reg [2:0] state_r;
	reg [2:0] op_r;
	reg [12:0] addr_r;
	reg [7:0] wdata_r;
	reg [7:0] rdata_r;
	reg busy_r;
	reg pass_r;
	reg fail_r;
	reg [4:0] pulses_r;
	reg [6:0] ms_left_r;
	reg over_r;
	reg tmr_load;
	reg [23:0] tmr_val;
	wire tmr_done;
	wire apb_acc;
	wire mapped;

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_s1_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n <= rst_s1_r;
		end
	end

	// Device data pins are asynchronous to clk
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			din_s1_r <= 8'h00;
			din_r <= 8'h00;
		end else begin
			din_s1_r <= data_i;
			din_r <= din_s1_r;
		end
	end

	epv_tmr u_tmr (
		.clk(clk),
		.rst_n(rst_n),
		.load(tmr_load),
		.val(tmr_val),
		.done(tmr_done)
	);

	// Zero wait states keep the master simple
	assign apb_acc = psel && penable;
	assign mapped = (paddr == `EPV_OFS_CTRL) || (paddr == `EPV_OFS_ADDR) ||
		(paddr == `EPV_OFS_WDATA) || (paddr == `EPV_OFS_STATUS) ||
		(paddr == `EPV_OFS_RDATA);
	assign pready = 1'b1;
	assign pslverr = apb_acc && !mapped;

	always @* begin
		prdata = 32'h00000000;
		case (paddr)
			`EPV_OFS_CTRL: prdata[`EPV_CTRL_OP_HI:`EPV_CTRL_OP_LO] = op_r;
			`EPV_OFS_ADDR: prdata[12:0] = addr_r;
			`EPV_OFS_WDATA: prdata[7:0] = wdata_r;
			`EPV_OFS_STATUS: begin
				prdata[`EPV_ST_BUSY] = busy_r;
				prdata[`EPV_ST_PASS] = pass_r;
				prdata[`EPV_ST_FAIL] = fail_r;
				prdata[`EPV_ST_CNT_HI:`EPV_ST_CNT_LO] = pulses_r;
			end
			`EPV_OFS_RDATA: prdata[7:0] = rdata_r;
			default: prdata = 32'h00000000;
		endcase
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= S_IDLE;
			op_r <= `EPV_OP_READ;
			addr_r <= `EPV_RST_ADDR;
			wdata_r <= `EPV_RST_DATA;
			rdata_r <= `EPV_RST_DATA;
			busy_r <= 1'b0;
			pass_r <= 1'b0;
			fail_r <= 1'b0;
			pulses_r <= 5'h00;
			ms_left_r <= 7'h00;
			over_r <= 1'b0;
			tmr_load <= 1'b0;
			tmr_val <= 24'h000000;
			vpp_vh <= 1'b0;
			vcc_prog <= 1'b0;
			memory_mode_select_vh <= 1'b0;
			memory_mode_select <= 1'b0;
			ce_vh <= 1'b0;
			ce_n <= 1'b1;
			oe_vh <= 1'b0;
			oe_n <= 1'b1;
			program_strobe_n <= 1'b1;
			addr <= `EPV_RST_ADDR;
			data_o <= `EPV_RST_DATA;
			data_oe <= 1'b1;
		end else begin
			tmr_load <= 1'b0;
			case (state_r)
				S_IDLE: begin
					if (apb_acc && pwrite && paddr == `EPV_OFS_ADDR) begin
						addr_r <= pwdata[12:0];
					end
					if (apb_acc && pwrite && paddr == `EPV_OFS_WDATA) begin
						wdata_r <= pwdata[7:0];
					end
					// Writes while busy are dropped so the pins stay coherent
					if (apb_acc && pwrite && paddr == `EPV_OFS_CTRL &&
						pwdata[`EPV_CTRL_START]) begin
						op_r <= pwdata[`EPV_CTRL_OP_HI:`EPV_CTRL_OP_LO];
						busy_r <= 1'b1;
						pass_r <= 1'b0;
						fail_r <= 1'b0;
						pulses_r <= 5'h00;
						over_r <= 1'b0;
						addr <= addr_r;
						data_o <= wdata_r;
						tmr_load <= 1'b1;
						tmr_val <= `EPV_SETUP_CYC;
						state_r <= S_SETUP;
						case (pwdata[`EPV_CTRL_OP_HI:`EPV_CTRL_OP_LO])
							`EPV_OP_READ: begin
								memory_mode_select_vh <= 1'b1;
								ce_n <= 1'b0;
								oe_n <= 1'b0;
								data_oe <= 1'b0;
							end
							`EPV_OP_PROG: begin
								vpp_vh <= 1'b1;
								vcc_prog <= 1'b1;
								ce_n <= 1'b0;
								data_oe <= 1'b1;
							end
							`EPV_OP_VERIFY: begin
								vpp_vh <= 1'b1;
								vcc_prog <= 1'b1;
								ce_n <= 1'b0;
								oe_n <= 1'b0;
								data_oe <= 1'b0;
							end
							`EPV_OP_MPROT: begin
								vpp_vh <= 1'b1;
								vcc_prog <= 1'b1;
								memory_mode_select_vh <= 1'b1;
								ce_vh <= 1'b1;
								addr <= `EPV_RST_ADDR;
								data_o <= `EPV_RST_DATA;
							end
							`EPV_OP_RPROT: begin
								vpp_vh <= 1'b1;
								vcc_prog <= 1'b1;
								memory_mode_select <= 1'b1;
								ce_vh <= 1'b1;
								oe_vh <= 1'b1;
								addr <= `EPV_RST_ADDR;
								data_o <= `EPV_RST_DATA;
							end
							default: begin
								busy_r <= 1'b0;
								fail_r <= 1'b1;
								tmr_load <= 1'b0;
								state_r <= S_IDLE;
							end
						endcase
					end
				end
				S_SETUP: begin
					if (tmr_done) begin
						tmr_load <= 1'b1;
						if (op_r == `EPV_OP_READ || op_r == `EPV_OP_VERIFY) begin
							tmr_val <= 24'h000000;
							state_r <= S_VERIFY;
						end else begin
							program_strobe_n <= 1'b0;
							tmr_val <= MS_CYC;
							// Overpulse length was set by the passing verify
							if (op_r == `EPV_OP_PROG && !over_r) begin
								ms_left_r <= 7'h01;
								pulses_r <= pulses_r + 5'h01;
							end else if (op_r != `EPV_OP_PROG) begin
								ms_left_r <= `EPV_OPT_PULSE_MS;
							end
							state_r <= S_PULSE;
						end
					end
				end
				S_PULSE: begin
					if (tmr_done) begin
						tmr_load <= 1'b1;
						if (ms_left_r == 7'h01) begin
							program_strobe_n <= 1'b1;
							tmr_val <= `EPV_SETUP_CYC;
							state_r <= S_HOLD;
						end else begin
							ms_left_r <= ms_left_r - 7'h01;
							tmr_val <= MS_CYC;
						end
					end
				end
				S_HOLD: begin
					if (tmr_done) begin
						tmr_load <= 1'b1;
						tmr_val <= `EPV_SETUP_CYC;
						if (op_r == `EPV_OP_PROG) begin
							// Switch to verify levels after the strobe has risen
							oe_n <= 1'b0;
							data_oe <= 1'b0;
							state_r <= S_VERIFY;
						end else begin
							pass_r <= 1'b1;
							state_r <= S_END;
						end
					end
				end
				S_VERIFY: begin
					// Read and verify: setup wait in the previous state covers data access time; program: the wait loaded on entry here does
					if (tmr_done) begin
						tmr_load <= 1'b1;
						tmr_val <= `EPV_SETUP_CYC;
						rdata_r <= din_r;
						if (op_r == `EPV_OP_READ) begin
							pass_r <= 1'b1;
							state_r <= S_END;
						end else if (op_r == `EPV_OP_VERIFY || over_r) begin
							pass_r <= (din_r == wdata_r);
							fail_r <= (din_r != wdata_r);
							state_r <= S_END;
						end else if (din_r == wdata_r) begin
							oe_n <= 1'b1;
							data_oe <= 1'b1;
							over_r <= 1'b1;
							ms_left_r <= {2'h0, pulses_r} * `EPV_OVER_MULT;
							state_r <= S_SETUP;
						end else if (pulses_r == `EPV_MAX_PULSES) begin
							fail_r <= 1'b1;
							state_r <= S_END;
						end else begin
							oe_n <= 1'b1;
							data_oe <= 1'b1;
							state_r <= S_SETUP;
						end
					end
				end
				S_END: begin
					if (tmr_done) begin
						busy_r <= 1'b0;
						state_r <= S_IDLE;
					end
				end
				default: state_r <= S_IDLE;
			endcase
			// Return every control pin and data_oe to its idle level on leaving the operation; addr and data_o keep their values
			if (state_r != S_END && state_r != S_IDLE &&
				tmr_done && (pass_r || fail_r || state_r == S_VERIFY &&
				(op_r != `EPV_OP_PROG || over_r ||
				pulses_r == `EPV_MAX_PULSES && din_r != wdata_r) ||
				state_r == S_HOLD && op_r != `EPV_OP_PROG ||
				state_r == S_VERIFY && op_r == `EPV_OP_READ)) begin
				vpp_vh <= 1'b0;
				vcc_prog <= 1'b0;
				memory_mode_select_vh <= 1'b0;
				memory_mode_select <= 1'b0;
				ce_vh <= 1'b0;
				ce_n <= 1'b1;
				oe_vh <= 1'b0;
				oe_n <= 1'b1;
				program_strobe_n <= 1'b1;
				data_oe <= 1'b1;
			end
		end
	end
endmodule

//--- logic/epv_defines.vh
`ifndef EPV_DEFINES_VH
`define EPV_DEFINES_VH

// APB register byte offsets
`define EPV_OFS_CTRL 8'h00
`define EPV_OFS_ADDR 8'h04
`define EPV_OFS_WDATA 8'h08
`define EPV_OFS_STATUS 8'h0C
`define EPV_OFS_RDATA 8'h10

// CTRL fields
`define EPV_CTRL_START 0
`define EPV_CTRL_OP_LO 1
`define EPV_CTRL_OP_HI 3

// STATUS fields
`define EPV_ST_BUSY 0
`define EPV_ST_PASS 1
`define EPV_ST_FAIL 2
`define EPV_ST_CNT_LO 8
`define EPV_ST_CNT_HI 12

// Operation codes
`define EPV_OP_READ 3'h0
`define EPV_OP_PROG 3'h1
`define EPV_OP_VERIFY 3'h2
`define EPV_OP_MPROT 3'h3
`define EPV_OP_RPROT 3'h4

// Reset values
`define EPV_RST_ADDR 13'h0000
`define EPV_RST_DATA 8'h00

// Target-side facts kept for reference by software
`define EPV_TGT_INT_MASK_ADDR 8'hFB
`define EPV_TGT_INT_MASK_RPROT_BIT 6

// Timing, in 8 ns clock cycles unless named otherwise
// Sized to the counter each one loads, so nothing is cut silently
// 2 us setup and hold time
`define EPV_SETUP_CYC 24'h0000FA
// One 1 ms pulse step
`define EPV_MS_CYC 24'h01E848
`define EPV_MAX_PULSES 5'h19
`define EPV_OVER_MULT 7'h03
`define EPV_OPT_PULSE_MS 7'h4E

`endif

//--- logic/epv_tmr.v
module epv_tmr (
	clk,
	rst_n,
	load,
	val,
	done
);
	input wire clk;
	input wire rst_n;
	input wire load;
	input wire [23:0] val;
	output wire done;

	reg [23:0] cnt_r;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 24'h000000;
		end else if (load) begin
			cnt_r <= val;
		end else if (cnt_r != 24'h000000) begin
			cnt_r <= cnt_r - 24'h000001;
		end
	end

	assign done = (cnt_r == 24'h000000) && !load;
endmodule

//--- bench/epv_dev_model.sv
module epv_dev (
	input wire vpp_vh,
	input wire vcc_prog,
	input wire memory_mode_select_vh,
	input wire memory_mode_select,
	input wire ce_vh,
	input wire ce_n,
	input wire oe_vh,
	input wire oe_n,
	input wire program_strobe_n,
	input wire [12:0] addr,
	input wire [7:0] data_o,
	input wire data_oe,
	output wire [7:0] data_i
);
	timeunit 1ns;
	timeprecision 1ps;
	reg [7:0] mem [0:15];
	reg [7:0] interrupt_mask_reg = 8'h00;
	reg mprot_r = 1'b0;
	reg rprot_r = 1'b0;
	time t0 = 0;
	time lw = 0;
	wire rd = memory_mode_select_vh && program_strobe_n;
	wire vf = vpp_vh && vcc_prog && program_strobe_n;
	wire drv = !ce_n && !oe_n && (rd || vf);
	// Protected array reads back scrambled
	wire [7:0] q = mem[addr[3:0]] ^ {8{mprot_r}};
	// Bus pull-ups when released
	assign data_i = drv ? q : 8'hFF;
	initial for (int i = 0; i < 16; i++) mem[i] = 8'hFF;
	always @(negedge program_strobe_n) t0 = $time;
	always @(posedge program_strobe_n) begin
		lw = $time - t0;
		if (vpp_vh && vcc_prog && !ce_n && oe_n && data_oe && !mprot_r)
			mem[addr[3:0]] = mem[addr[3:0]] & data_o;
		if (vpp_vh && ce_vh && memory_mode_select_vh && !oe_vh)
			mprot_r = 1'b1;
		if (vpp_vh && ce_vh && oe_vh && memory_mode_select)
			rprot_r = interrupt_mask_reg[6];
	end
endmodule

//--- bench/epv_host_assertions.sv
module epv_host_assertions #(
	parameter MS_CYC = 50
) (
	input wire clk,
	input wire nrst,
	input wire vpp_vh,
	input wire vcc_prog,
	input wire memory_mode_select_vh,
	input wire ce_vh,
	input wire ce_n,
	input wire oe_n,
	input wire program_strobe_n,
	input wire data_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int OPT = 78 * MS_CYC;
	reg [23:0] low_cnt;
	always @(posedge clk or negedge nrst) begin
		if (!nrst)
			low_cnt <= 24'h000000;
		else if (program_strobe_n)
			low_cnt <= 24'h000000;
		else
			low_cnt <= low_cnt + 24'h000001;
	end
	// Previous-cycle copies for the pulse-end detector
	reg ce_n_d;
	reg strobe_n_d;
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ce_n_d <= 1'b1;
			strobe_n_d <= 1'b1;
		end else begin
			ce_n_d <= ce_n;
			strobe_n_d <= program_strobe_n;
		end
	end
	wire pend = !ce_n_d && !strobe_n_d && program_strobe_n;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	property p_vcc; vpp_vh && !ce_n && !oe_n |-> vcc_prog; endproperty
	a_vcc: assert property (p_vcc) else $error("verify supply");
	property p_pdir; !program_strobe_n && !ce_n |-> oe_n && data_oe; endproperty
	a_pdir: assert property (p_pdir) else $error("program dir");
	property p_vdir; !ce_n && !oe_n |-> !data_oe; endproperty
	a_vdir: assert property (p_vdir) else $error("verify dir");
	property p_svpp; !program_strobe_n |-> vpp_vh && vcc_prog; endproperty
	a_svpp: assert property (p_svpp) else $error("strobe levels");
	property p_read;
		!ce_n && !oe_n && !vpp_vh |-> memory_mode_select_vh && program_strobe_n;
	endproperty
	a_read: assert property (p_read) else $error("read levels");
	property p_opt; $rose(program_strobe_n) && $past(ce_vh) |-> low_cnt >= OPT;
	endproperty
	a_opt: assert property (p_opt) else $error("option pulse");
	property p_ms; pend |-> low_cnt >= MS_CYC; endproperty
	a_ms: assert property (p_ms) else $error("short pulse");
	property p_hold; pend |-> data_oe [*8]; endproperty
	a_hold: assert property (p_hold) else $error("data hold");
	c_ver: cover property (!ce_n && !oe_n && vpp_vh);
	c_rd: cover property (!ce_n && !oe_n && memory_mode_select_vh);
	c_opt: cover property ($rose(program_strobe_n) && $past(ce_vh));
endmodule
bind epv_host epv_host_assertions #(.MS_CYC(MS_CYC)) chk_u (
	.clk(clk), .nrst(nrst), .vpp_vh(vpp_vh), .vcc_prog(vcc_prog),
	.memory_mode_select_vh(memory_mode_select_vh), .ce_vh(ce_vh),
	.ce_n(ce_n), .oe_n(oe_n), .program_strobe_n(program_strobe_n),
	.data_oe(data_oe));

//--- bench/eprom_verify_and_protect_test.sv
`include "epv_defines.vh"
module eprom_verify_and_protect_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam MS = 50;
	reg clk = 1'b0;
	reg nrst = 1'b0;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h0;
	wire [31:0] prdata;
	wire pready, pslverr, vpp_vh, vcc_prog, mvh, mms, ce_vh, ce_n, oe_vh;
	wire oe_n, strobe_n, data_oe;
	wire [12:0] addr;
	wire [7:0] data_o, data_i;
	integer errors = 0;
	integer check_count = 0;
	integer cycles = 0;
	reg [31:0] st, rd;
	reg se;
	epv_host #(.MS_CYC(MS)) dut_u (.clk(clk), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.vpp_vh(vpp_vh), .vcc_prog(vcc_prog), .memory_mode_select_vh(mvh),
		.memory_mode_select(mms), .ce_vh(ce_vh), .ce_n(ce_n), .oe_vh(oe_vh),
		.oe_n(oe_n), .program_strobe_n(strobe_n), .addr(addr),
		.data_o(data_o), .data_oe(data_oe), .data_i(data_i));
	epv_dev dev_u (.vpp_vh(vpp_vh), .vcc_prog(vcc_prog),
		.memory_mode_select_vh(mvh), .memory_mode_select(mms),
		.ce_vh(ce_vh), .ce_n(ce_n), .oe_vh(oe_vh), .oe_n(oe_n),
		.program_strobe_n(strobe_n), .addr(addr), .data_o(data_o),
		.data_oe(data_oe), .data_i(data_i));
	initial forever #4 clk = ~clk;
	task results;
		begin
			$display("checks %0d mismatches %0d", check_count, errors);
			if (errors == 0 && check_count > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			errors = errors + 1;
			results;
		end
	end
	task chk(input string nm, input [31:0] e, input [31:0] g);
		begin
			check_count = check_count + 1;
			if (g !== e) begin
				errors = errors + 1;
				$display("CHECK FAILED %s exp %h got %h", nm, e, g);
			end
		end
	endtask
	task apb(input w, input [7:0] a, input [31:0] d);
		begin
			@(posedge clk);
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clk);
			penable <= 1'b1;
			do @(posedge clk); while (pready !== 1'b1);
			rd = prdata;
			se = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task op(input [2:0] o, input [12:0] a, input [7:0] d);
		begin
			apb(1'b1, `EPV_OFS_ADDR, {19'h0, a});
			apb(1'b1, `EPV_OFS_WDATA, {24'h0, d});
			apb(1'b1, `EPV_OFS_CTRL, {28'h0, o, 1'b1});
			do apb(1'b0, `EPV_OFS_STATUS, 32'h0); while (rd[0] !== 1'b0);
			st = rd;
			apb(1'b0, `EPV_OFS_RDATA, 32'h0);
		end
	endtask
	task t_regs;
		begin
			apb(1'b0, `EPV_OFS_ADDR, 32'h0);
			chk("addr", 32'h0, rd);
			apb(1'b0, 8'h20, 32'h0);
			chk("slverr", 32'h1, se);
			$display("done regs");
		end
	endtask
	task t_prog;
		begin
			op(`EPV_OP_PROG, 13'h0003, 8'hA5);
			chk("pass", 32'h1, st[1]);
			chk("pulses", 32'h1, st[12:8]);
			chk("overpulse", 32'h1, dev_u.lw >= 3 * MS * 8);
			op(`EPV_OP_READ, 13'h0003, 8'h00);
			chk("read", 32'hA5, rd[7:0]);
			op(`EPV_OP_VERIFY, 13'h0003, 8'h00);
			chk("verify", 32'hA5, rd[7:0]);
			op(3'h7, 13'h0003, 8'h00);
			chk("badop", 32'h1, st[2]);
			$display("done program");
		end
	endtask
	task t_prot;
		integer i;
		begin
			for (i = 0; i < 2; i = i + 1) begin
				dev_u.interrupt_mask_reg = i ? 8'h40 : 8'h00;
				op(`EPV_OP_RPROT, 13'h0000, 8'h00);
				chk("ramprot", i, dev_u.rprot_r);
			end
			op(`EPV_OP_MPROT, 13'h0000, 8'h00);
			chk("memprot", 32'h1, dev_u.mprot_r);
			op(`EPV_OP_READ, 13'h0003, 8'h00);
			chk("lockread", 32'h5A, rd[7:0]);
			op(`EPV_OP_PROG, 13'h0005, 8'h3C);
			chk("lockfail", 32'h1, st[2]);
			chk("maxpulses", 32'd25, st[12:8]);
			$display("done protect");
		end
	endtask
	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		t_regs;
		t_prog;
		t_prot;
		results;
	end
endmodule
